/* File: src/pdc_consts.vh */
// constants for the power-down and calibration control block
// How it works
// R1: after any calibration command the controller sends only no-operations for its period.
// R2: clock enable stays sampled high through every calibration period.
// R3: all data-bus drivers should float while a calibration runs.
// R4: devices sharing one calibration resistor never calibrate at overlapping times.
// R5: power-down entry is clock enable low, select high, after clock enable high.
// R6: a no-operation follows every power-down or deep power-down entry command.
// R7: clock enable never drops while a config access, read or write runs.
// R8: activate, precharge and refresh may run on; low power waits for them.
// R9: power-down with all banks idle is idle, otherwise active power-down.
// R10: in power-down only clock pair and clock enable buffers stay on.
// R11: clock enable stays low at least the minimum pulse time.
// R12: no refresh runs inside power-down; controller exits in time.
// R13: exit on clock enable high with select high; command after exit latency. The block also exits with select low and flags it.
// R14: clock stable for at least 2 cycles before any exit.
// R15: read to entry waits read latency, strobe access, half burst, plus one.
// R16: write to entry waits write latency, one, half burst, recovery; autoprecharge adds one.
// R17: refresh, activate or precharge to entry waits the gate hold time.
// R18: config write to entry waits the config write period.
// R19: deep entry is clock enable low, select low, bits 0,1 high, bit 2 low.
// R20: deep entry needs idle banks, quiet data bus, clock enable held low throughout. The block does not check banks_idle on deep entry.
// R21: deep power-down may drop all buffers but clock enable, and core power.
// R22: deep exit on clock enable and select high; full re-initialisation follows.
// R23: no-operation is select high, or select low with bits 0,1,2 high.
// R24: controller keeps per-device counters for every power and calibration limit.
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH
`define PDC_CLK_MHZ 50
// calibration quiet times in ns
`define PDC_SHORT_CAL_NS 100
`define PDC_LONG_CAL_NS 400
`define PDC_CAL_RESET_NS 60
// time converted to clk cycles, rounded up
`define PDC_NS2CYC(ns) (((ns) * `PDC_CLK_MHZ + 999) / 1000)
// calibration kinds
`define PDC_CAL_SHORT 2'h0
`define PDC_CAL_LONG 2'h1
`define PDC_CAL_RESET 2'h2
// command bit positions
`define PDC_B0 0
`define PDC_B1 1
`define PDC_B2 2
`define PDC_B3 3
// default link-edge lengths of internal operations
`define PDC_ACCESS_EDGES 8
`define PDC_ROWOP_EDGES 4
`endif

/* File: src/pdc_sync.v */
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module pdc_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // pins and synchronised copy
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (!nrst) begin
      meta_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* File: src/pdc_top.v */
// power-state tracking and calibration quiet control inside the SDRAM
`timescale 1ns/100ps
`include "pdc_consts.vh"
module pdc_top #(
  parameter ACCESS_EDGES = `PDC_ACCESS_EDGES,
  parameter ROWOP_EDGES = `PDC_ROWOP_EDGES
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // link pins from the controller
  input wire link_ck,
  input wire cke,
  input wire cs_n,
  input wire cmd_bit0,
  input wire cmd_bit1,
  input wire cmd_bit2,
  input wire cmd_bit3,
  // device-internal requests
  input wire banks_idle,
  input wire cal_start,
  input wire [1:0] cal_kind,
  input wire init_done,
  input wire err_clr,
  // power state
  output reg pd_idle_q,
  output reg pd_active_q,
  output reg deep_pd_q,
  output reg low_power_q,
  output reg in_buf_en_q,
  output reg out_buf_en_q,
  output reg core_pwr_en_q,
  output reg refresh_en_q,
  output reg reinit_needed_q,
  // calibration
  output reg cal_busy_q,
  output reg cal_res_en_q,
  // protocol fault, sticky
  output reg proto_err_q
);
  // power states
  localparam ST_NORM = 2'h0;
  localparam ST_PD = 2'h1;
  localparam ST_DPD = 2'h2;
  localparam integer SHORT_NUM = `PDC_NS2CYC(`PDC_SHORT_CAL_NS);
  localparam integer LONG_NUM = `PDC_NS2CYC(`PDC_LONG_CAL_NS);
  localparam integer RESET_NUM = `PDC_NS2CYC(`PDC_CAL_RESET_NS);
  // counters are 8 bits; longer periods would need a wider counter
  localparam [7:0] SHORT_CYC = SHORT_NUM[7:0];
  localparam [7:0] LONG_CYC = LONG_NUM[7:0];
  localparam [7:0] RESET_CYC = RESET_NUM[7:0];
  localparam [7:0] ACC_LEN = ACCESS_EDGES[7:0];
  localparam [7:0] ROW_LEN = ROWOP_EDGES[7:0];

  wire [6:0] pins_s;
  reg ck_prev_q;
  // clock enable of the previous link edge; access, row and entry decodes need it high, the no-operation and exit decodes do not
  reg cke_prev_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] acc_cnt_q;
  reg [7:0] row_cnt_q;
  reg [7:0] cal_cnt_q;
  reg set_err;

  // ck is only a sampled level here; bench runs it at 160 ns
  pdc_sync #(.W(7)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din({link_ck, cke, cs_n, cmd_bit3, cmd_bit2, cmd_bit1, cmd_bit0}),
    .dout(pins_s)
  );

  wire ck_s = pins_s[6];
  wire cke_s = pins_s[5];
  wire cs_n_s = pins_s[4];
  wire [3:0] cmd_s = pins_s[3:0];
  wire ck_rise = ck_s & ~ck_prev_q;

  // command decode; access and row decodes need clock enable high on both edges, the no-operation decode does not
  function is_cmd;
    input [3:0] c;
    input [3:0] pat;
    input [3:0] care;
    begin
      is_cmd = ((c ^ pat) & care) == 4'h0;
    end
  endfunction

  wire live = ~cs_n_s & cke_s & cke_prev_q;
  wire cmd_access = live & (is_cmd(cmd_s, 4'h0, 4'h6) | is_cmd(cmd_s, 4'h1, 4'h3));
  wire cmd_rowop = live & (is_cmd(cmd_s, 4'hC, 4'hF) | is_cmd(cmd_s, 4'h2, 4'h3)
                   | is_cmd(cmd_s, 4'h3, 4'h7));
  wire cmd_nop = cs_n_s | is_cmd(cmd_s, 4'h7, 4'h7);
  wire cke_fall = cke_prev_q & ~cke_s;

  // calibration period in clk cycles for each kind
  function [7:0] cal_len;
    input [1:0] k;
    begin
      case (k)
        `PDC_CAL_LONG: cal_len = LONG_CYC;
        `PDC_CAL_RESET: cal_len = RESET_CYC;
        default: cal_len = SHORT_CYC;
      endcase
    end
  endfunction

  // next state moves only on a link edge
  always @* begin
    state_d = state_q;
    set_err = 1'b0;
    if (ck_rise) begin
      case (state_q)
        ST_NORM: begin
          if (cke_fall) begin
            if (cs_n_s)
              state_d = ST_PD; // see R5
            else if (is_cmd(cmd_s, 4'h3, 4'h7))
              state_d = ST_DPD; // see R19
            else
              set_err = 1'b1;
            // config, read and write must have finished
            if (acc_cnt_q != 8'h0)
              set_err = 1'b1; // see R7
            if (cal_busy_q)
              set_err = 1'b1; // see R2
          end else if (cal_busy_q && cke_prev_q && !cmd_nop) begin
            set_err = 1'b1; // see R1
          end
        end
        ST_PD: begin
          // select low on exit is flagged, but the exit still happens
          if (cke_s) begin
            state_d = ST_NORM; // see R13
            if (!cs_n_s)
              set_err = 1'b1; // see R13
          end
        end
        ST_DPD: begin
          // any other pin pattern leaves the device asleep
          if (cke_s && cs_n_s)
            state_d = ST_NORM; // see R22
        end
        default: state_d = ST_NORM;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      ck_prev_q <= 1'b0;
      cke_prev_q <= 1'b0;
      state_q <= ST_NORM;
      acc_cnt_q <= 8'h00;
      row_cnt_q <= 8'h00;
      cal_cnt_q <= 8'h00;
      pd_idle_q <= 1'b0;
      pd_active_q <= 1'b0;
      deep_pd_q <= 1'b0;
      low_power_q <= 1'b0;
      in_buf_en_q <= 1'b1;
      out_buf_en_q <= 1'b1;
      core_pwr_en_q <= 1'b1;
      refresh_en_q <= 1'b1;
      reinit_needed_q <= 1'b0;
      cal_busy_q <= 1'b0;
      cal_res_en_q <= 1'b0;
      proto_err_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_s;
      if (ck_rise)
        cke_prev_q <= cke_s;
      state_q <= state_d;
      // read, write and config accesses count link edges
      if (ck_rise) begin
        if (cmd_access && state_q == ST_NORM)
          acc_cnt_q <= ACC_LEN;
        else if (acc_cnt_q != 8'h0)
          acc_cnt_q <= acc_cnt_q - 8'h01;
        // row operations keep running into power-down
        if (cmd_rowop && state_q == ST_NORM)
          row_cnt_q <= ROW_LEN; // see R8
        else if (row_cnt_q != 8'h0)
          row_cnt_q <= row_cnt_q - 8'h01;
      end
      // calibration timed on clk since its period is absolute time
      // a start inside a running period is dropped, never restarted
      if (cal_start && !cal_busy_q && state_q == ST_NORM) begin
        cal_cnt_q <= cal_len(cal_kind);
        cal_busy_q <= 1'b1;
      end else if (cal_cnt_q > 8'h01) begin
        cal_cnt_q <= cal_cnt_q - 8'h01;
      end else begin
        cal_cnt_q <= 8'h00;
        cal_busy_q <= 1'b0;
      end
      // resistor current path follows the calibration busy flag one clk later
      cal_res_en_q <= cal_busy_q;
      if (ck_rise && state_q == ST_NORM && state_d == ST_PD) begin
        pd_idle_q <= banks_idle; // see R9
        pd_active_q <= ~banks_idle; // see R9
      end else if (state_d != ST_PD) begin
        pd_idle_q <= 1'b0;
        pd_active_q <= 1'b0;
      end
      deep_pd_q <= (state_d == ST_DPD);
      // low consumption only once row operations have drained
      low_power_q <= (state_d == ST_PD) && (row_cnt_q == 8'h0); // see R8
      in_buf_en_q <= (state_d == ST_NORM); // see R10
      out_buf_en_q <= (state_d == ST_NORM); // see R10
      core_pwr_en_q <= (state_d != ST_DPD); // see R21
      refresh_en_q <= (state_d == ST_NORM); // see R12
      if (ck_rise && state_q == ST_DPD && state_d == ST_NORM)
        reinit_needed_q <= 1'b1; // see R22
      else if (init_done)
        reinit_needed_q <= 1'b0;
      // set wins over clear
      if (set_err)
        proto_err_q <= 1'b1;
      else if (err_clr)
        proto_err_q <= 1'b0;
    end
  end
endmodule

/* File: dv/pdc_sva.sv */
// port assertions for the power-down and calibration block
`timescale 1ns/100ps
module pdc_sva (
  // clock and reset
  input wire clk,
  input wire nrst,
  // link pins
  input wire cke,
  input wire cs_n,
  input wire cmd_bit0,
  input wire cmd_bit1,
  input wire cmd_bit2,
  input wire cal_start,
  // state outputs
  input wire pd_idle_q,
  input wire pd_active_q,
  input wire deep_pd_q,
  input wire in_buf_en_q,
  input wire out_buf_en_q,
  input wire core_pwr_en_q,
  input wire refresh_en_q,
  input wire reinit_needed_q,
  input wire cal_busy_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire pd = pd_idle_q | pd_active_q;
  // pins are held about four clk around each link edge, so depth 3 lands inside
  buf_off_a: assert property (pd | deep_pd_q |-> !in_buf_en_q && !out_buf_en_q && !refresh_en_q)
    else $error("buffers on while powered down");
  pd_kind_a: assert property (!(pd_idle_q && pd_active_q) && !(pd && deep_pd_q))
    else $error("two power states at once");
  deep_core_a: assert property (deep_pd_q |-> !core_pwr_en_q)
    else $error("core powered in deep power-down");
  pd_entry_a: assert property ($rose(pd) |-> !$past(cke, 3) && $past(cs_n, 3))
    else $error("power-down without entry pins");
  deep_entry_a: assert property ($rose(deep_pd_q) |-> !$past(cke, 3) && !$past(cs_n, 3)
    && $past(cmd_bit0, 3) && $past(cmd_bit1, 3) && !$past(cmd_bit2, 3))
    else $error("deep power-down without entry pins");
  pd_exit_a: assert property ($fell(pd) |-> $past(cke, 3))
    else $error("power-down left without clock enable");
  deep_exit_a: assert property ($fell(deep_pd_q) |-> ##[0:1] reinit_needed_q)
    else $error("no re-initialisation flag after deep exit");
  cal_len_a: assert property ($rose(cal_busy_q) |-> cal_busy_q[*3] ##[1:18] !cal_busy_q)
    else $error("calibration period length wrong");
  cal_go_a: assert property (cal_start && !cal_busy_q && in_buf_en_q |=> cal_busy_q)
    else $error("calibration not started");
endmodule
bind pdc_top pdc_sva pdc_sva_inst (.*);

/* File: dv/pdc_ctl_model.sv */
// controller side of the link: clock, clock enable, select and command bits
`timescale 1ns/100ps
module pdc_ctl_model (
  // link pins
  output reg link_ck,
  output reg cke,
  output reg cs_n,
  output reg [3:0] cmd
);
  // idle holds a no-operation with clock enable high
  // single device, no shared resistor and no data bus driven
  initial begin
    link_ck = 1'b0;
    cke = 1'b1;
    cs_n = 1'b1;
    cmd = 4'hF;
  end
  always #80 link_ck = ~link_ck;
  // change at the falling edge so the pins stand still across the rising one
  task send(input k, input s, input [3:0] c);
    begin
      @(negedge link_ck);
      cke <= k;
      cs_n <= s;
      cmd <= c;
      @(posedge link_ck);
    end
  endtask
  task enter(input s, input [3:0] c);
    integer i;
    begin
      send(1'b1, 1'b1, 4'hF);
      send(1'b0, s, c);
      // ignored command bits toggle so no stale value looks valid
      for (i = 0; i < 4; i = i + 1)
        send(1'b0, 1'b1, {i[0], ~i[0], i[0], ~i[0]});
    end
  endtask
  task leave;
    begin
      send(1'b1, 1'b1, 4'hF);
      send(1'b1, 1'b1, 4'hF);
    end
  endtask
endmodule

/* File: dv/pdc_top_tb.sv */
// self-checking bench for the power-down and calibration block
`timescale 1ns/100ps
`include "pdc_consts.vh"
module pdc_top_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg banks_idle = 1'b1;
  reg cal_start = 1'b0;
  reg [1:0] cal_kind = 2'h0;
  reg init_done = 1'b0;
  reg err_clr = 1'b0;
  reg [31:0] rnd = 32'h52C3;
  wire link_ck, cke, cs_n, pd_idle_q, pd_active_q, deep_pd_q, in_buf_en_q, out_buf_en_q;
  wire core_pwr_en_q, refresh_en_q, reinit_needed_q, cal_busy_q, proto_err_q;
  wire low_power_q, cal_res_en_q;
  wire [3:0] cmd;
  integer err_count = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer n, m, k, bi;
  always #10 clk = ~clk;
  pdc_ctl_model pdc_ctl_model_inst (.link_ck(link_ck), .cke(cke), .cs_n(cs_n), .cmd(cmd));
  pdc_top pdc_top_inst (.clk(clk), .nrst(nrst), .link_ck(link_ck), .cke(cke), .cs_n(cs_n),
    .cmd_bit0(cmd[0]), .cmd_bit1(cmd[1]), .cmd_bit2(cmd[2]), .cmd_bit3(cmd[3]),
    .banks_idle(banks_idle), .cal_start(cal_start), .cal_kind(cal_kind),
    .init_done(init_done), .err_clr(err_clr), .pd_idle_q(pd_idle_q),
    .pd_active_q(pd_active_q), .deep_pd_q(deep_pd_q), .low_power_q(low_power_q),
    .in_buf_en_q(in_buf_en_q), .out_buf_en_q(out_buf_en_q), .core_pwr_en_q(core_pwr_en_q),
    .refresh_en_q(refresh_en_q), .reinit_needed_q(reinit_needed_q),
    .cal_busy_q(cal_busy_q), .cal_res_en_q(cal_res_en_q), .proto_err_q(proto_err_q));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [7:0] s, input [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // a second start mid-period must neither restart nor stretch it
  task cal(input [1:0] kd, input integer exp);
    begin
      @(posedge clk);
      cal_kind <= kd;
      cal_start <= 1'b1;
      n = 0;
      m = 0;
      repeat (30) begin
        @(posedge clk);
        cal_start <= (n == 1);
        #1 if (cal_busy_q === 1'b1) n = n + 1;
        if (cal_res_en_q === 1'b1) m = m + 1;
      end
      chk(n, exp);
      chk(m, exp);
    end
  endtask
  // fault flag must stand, then clear on a one-cycle err_clr pulse
  task err_seen;
    begin
      @(posedge clk);
      err_clr <= 1'b1;
      #1 chk({7'h0, proto_err_q}, 8'h01);
      @(posedge clk);
      err_clr <= 1'b0;
      #1 chk({7'h0, proto_err_q}, 8'h00);
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk({in_buf_en_q, out_buf_en_q, core_pwr_en_q, refresh_en_q, pd_idle_q, pd_active_q,
      deep_pd_q, cal_busy_q}, 8'hF0);
    for (k = 0; k < 4; k = k + 1)
      cal(k[1:0], k == 1 ? 20 : k == 2 ? 3 : 5);
    for (k = 0; k < 4; k = k + 1) begin
      rnd = xs(rnd);
      bi = rnd[0];
      @(posedge clk);
      banks_idle <= rnd[0];
      pdc_ctl_model_inst.enter(1'b1, 4'hF);
      chk({2'h0, low_power_q, pd_idle_q, pd_active_q, in_buf_en_q, out_buf_en_q,
        refresh_en_q}, {2'h0, 1'b1, bi[0], !bi[0], 3'h0});
      pdc_ctl_model_inst.leave;
      chk({4'h0, pd_idle_q, pd_active_q, in_buf_en_q, refresh_en_q}, 8'h03);
    end
    @(posedge clk);
    banks_idle <= 1'b1;
    pdc_ctl_model_inst.enter(1'b0, 4'h3);
    chk({3'h0, deep_pd_q, core_pwr_en_q, in_buf_en_q, out_buf_en_q, proto_err_q}, 8'h10);
    pdc_ctl_model_inst.leave;
    chk({6'h0, deep_pd_q, reinit_needed_q}, 8'h01);
    @(posedge clk);
    init_done <= 1'b1;
    @(posedge clk);
    init_done <= 1'b0;
    #1 chk({7'h0, reinit_needed_q}, 8'h00);
    // activate right before entry: low consumption waits for the row operation
    @(posedge clk);
    banks_idle <= 1'b0;
    pdc_ctl_model_inst.send(1'b1, 1'b0, 4'h2);
    pdc_ctl_model_inst.send(1'b0, 1'b1, 4'hF);
    repeat (5) @(posedge clk);
    #1 chk({6'h0, pd_active_q, low_power_q}, 8'h02);
    repeat (`PDC_ROWOP_EDGES) pdc_ctl_model_inst.send(1'b0, 1'b1, 4'hF);
    repeat (5) @(posedge clk);
    #1 chk({6'h0, pd_active_q, low_power_q}, 8'h03);
    pdc_ctl_model_inst.leave;
    // read still running when clock enable drops
    pdc_ctl_model_inst.send(1'b1, 1'b0, 4'h5);
    pdc_ctl_model_inst.enter(1'b1, 4'hF);
    pdc_ctl_model_inst.leave;
    err_seen;
    // power-down left with select low
    pdc_ctl_model_inst.enter(1'b1, 4'hF);
    pdc_ctl_model_inst.send(1'b1, 1'b0, 4'hF);
    pdc_ctl_model_inst.send(1'b1, 1'b1, 4'hF);
    err_seen;
    // a command other than no-operation inside a long calibration
    @(posedge clk);
    cal_kind <= 2'h1;
    cal_start <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    pdc_ctl_model_inst.send(1'b1, 1'b0, 4'h2);
    pdc_ctl_model_inst.send(1'b1, 1'b1, 4'hF);
    err_seen;
    // let that period run out so the next start is taken
    repeat (20) @(posedge clk);
    // clock enable dropped inside a long calibration on purpose
    @(posedge clk);
    cal_kind <= 2'h1;
    cal_start <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    pdc_ctl_model_inst.send(1'b0, 1'b1, 4'hF);
    pdc_ctl_model_inst.leave;
    err_seen;
    print_verdict;
  end
endmodule
